// File: dir_fabric_reader.sv
`timescale 1ns/1ps
module dir_fabric_reader #(
    parameter int ID_BITS = dir_pkg::ID_WIDTH
) (
    input wire logic clk_i,
    input wire logic reset_i,
    dir_link_if.fabric link,
    input wire logic start_i,
    input wire logic [1:0] fill_mode_i,
    input wire logic fill_bit_i,
    output logic busy_o,
    output logic done_o,
    output logic [ID_BITS-1:0] id_o
);
    import dir_pkg::*;
    typedef enum logic [1:0] {RD_IDLE, RD_LOAD, RD_SHIFT, RD_DONE} dir_rd_type;
    dir_rd_type st_reg, st_next;
    logic [ID_BITS-1:0] id_reg, id_next;
    logic [6:0] cnt_reg, cnt_next;

    initial begin
        if (ID_BITS < 2 || ID_BITS > 127) $error("bad identifier width");
    end

    // load one cycle, then sample bit and shift once for each of the ID_BITS bits
    always_comb begin
        st_next = st_reg;
        id_next = id_reg;
        cnt_next = cnt_reg;
        unique case (st_reg)
            RD_IDLE: if (start_i) st_next = RD_LOAD;
            RD_LOAD: begin
                st_next = RD_SHIFT;
                cnt_next = '0;
            end
            RD_SHIFT: begin
                id_next = {link.serial_out, id_reg[ID_BITS-1:1]};
                cnt_next = cnt_reg + 7'h01;
                if (cnt_reg == 7'(ID_BITS - 1)) st_next = RD_DONE;
            end
            RD_DONE: st_next = RD_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= RD_IDLE;
            id_reg <= '0;
            cnt_reg <= '0;
        end else begin
            st_reg <= st_next;
            id_reg <= id_next;
            cnt_reg <= cnt_next;
        end
    end

    assign link.read_load = (st_reg == RD_LOAD);
    assign link.shift_en = (st_reg == RD_SHIFT);
    // fill: 1 recirculate, 0 2 and 3 all feed fill_bit_i
    assign link.serial_in = (fill_mode_i == 2'h1) ? link.serial_out : fill_bit_i;
    assign busy_o = (st_reg != RD_IDLE);
    assign done_o = (st_reg == RD_DONE);
    assign id_o = id_reg;
endmodule

// File: dir_identifier_access_port.sv
`timescale 1ns/1ps
module dir_identifier_access_port #(
    parameter logic [91:0] ID_BODY = 92'h0123456789abcdef0123456,
    parameter logic [dir_pkg::FUSE_WIDTH-1:0] USER_FUSE = 32'h00000000
) (
    input wire logic clk_i,
    input wire logic reset_i,
    dir_link_if.device link,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o
);
    import dir_pkg::*;
    typedef enum logic [3:0] {
        TST_RESET, TST_IDLE, TST_SEL_DR, TST_CAP_DR, TST_SHIFT_DR, TST_EXIT1_DR, TST_PAUSE_DR,
        TST_EXIT2_DR, TST_UPD_DR, TST_SEL_IR, TST_CAP_IR, TST_SHIFT_IR, TST_EXIT1_IR,
        TST_PAUSE_IR, TST_EXIT2_IR, TST_UPD_IR
    } dir_tap_type;

    // identifier with fixed ends
    logic [ID_WIDTH-1:0] identifier;
    assign identifier = {ID_MSB_MARK, ID_BODY, ID_LSB_MARK};

    // fabric path
    dir_shift_reg #(.WIDTH(ID_WIDTH)) u_fabric (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .load_i(link.read_load),
        .shift_i(link.shift_en),
        .serial_i(link.serial_in),
        .load_value_i(identifier),
        .serial_o(link.serial_out)
    );

    // test port pins synchronised into clk_i
    logic [2:0] pin_meta_reg, pin_sync_reg, tck_last_reg;
    logic tck_rise, tck_fall;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            tck_last_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {tck_i, tms_i, tdi_i};
            pin_sync_reg <= pin_meta_reg;
            tck_last_reg <= pin_sync_reg;
        end
    end
    assign tck_rise = pin_sync_reg[2] & ~tck_last_reg[2];
    assign tck_fall = ~pin_sync_reg[2] & tck_last_reg[2];

    dir_tap_type tap_reg, tap_next;
    logic [IR_WIDTH-1:0] ir_reg, ir_next, irs_reg, irs_next;
    logic [ID_WIDTH-1:0] dr_reg, dr_next;
    logic tdo_reg, tdo_next;

    // tap controller step
    function automatic dir_tap_type tap_step(dir_tap_type s, logic m);
        unique case (s)
            TST_RESET: tap_step = m ? TST_RESET : TST_IDLE;
            TST_IDLE: tap_step = m ? TST_SEL_DR : TST_IDLE;
            TST_SEL_DR: tap_step = m ? TST_SEL_IR : TST_CAP_DR;
            TST_CAP_DR: tap_step = m ? TST_EXIT1_DR : TST_SHIFT_DR;
            TST_SHIFT_DR: tap_step = m ? TST_EXIT1_DR : TST_SHIFT_DR;
            TST_EXIT1_DR: tap_step = m ? TST_UPD_DR : TST_PAUSE_DR;
            TST_PAUSE_DR: tap_step = m ? TST_EXIT2_DR : TST_PAUSE_DR;
            TST_EXIT2_DR: tap_step = m ? TST_UPD_DR : TST_SHIFT_DR;
            TST_UPD_DR: tap_step = m ? TST_SEL_DR : TST_IDLE;
            TST_SEL_IR: tap_step = m ? TST_RESET : TST_CAP_IR;
            TST_CAP_IR: tap_step = m ? TST_EXIT1_IR : TST_SHIFT_IR;
            TST_SHIFT_IR: tap_step = m ? TST_EXIT1_IR : TST_SHIFT_IR;
            TST_EXIT1_IR: tap_step = m ? TST_UPD_IR : TST_PAUSE_IR;
            TST_PAUSE_IR: tap_step = m ? TST_EXIT2_IR : TST_PAUSE_IR;
            TST_EXIT2_IR: tap_step = m ? TST_UPD_IR : TST_SHIFT_IR;
            TST_UPD_IR: tap_step = m ? TST_SEL_DR : TST_IDLE;
        endcase
    endfunction

    // capture on rising tck, tdo updated on falling tck
    always_comb begin
        tap_next = tap_reg;
        ir_next = ir_reg;
        irs_next = irs_reg;
        dr_next = dr_reg;
        tdo_next = tdo_reg;
        if (tck_rise) begin
            tap_next = tap_step(tap_reg, pin_sync_reg[1]);
            unique case (tap_reg)
                TST_RESET: ir_next = IR_BYPASS;
                TST_CAP_IR: irs_next = {{(IR_WIDTH-1){1'b0}}, 1'b1};
                TST_SHIFT_IR: irs_next = {pin_sync_reg[0], irs_reg[IR_WIDTH-1:1]};
                TST_UPD_IR: ir_next = irs_reg;
                TST_CAP_DR: begin
                    if (ir_reg == IR_IDENTIFIER_READ) begin
                        dr_next = identifier;
                    end else if (ir_reg == IR_USER_FUSE_READ) begin
                        dr_next = {{(ID_WIDTH-FUSE_WIDTH){1'b0}}, USER_FUSE};
                    end else begin
                        dr_next = '0;
                    end
                end
                TST_SHIFT_DR: dr_next = {pin_sync_reg[0], dr_reg[ID_WIDTH-1:1]};
                default: ;
            endcase
        end
        if (tck_fall) begin
            if (tap_reg == TST_SHIFT_DR) begin
                tdo_next = dr_reg[0];
            end else if (tap_reg == TST_SHIFT_IR) begin
                tdo_next = irs_reg[0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tap_reg <= TST_RESET;
            ir_reg <= IR_BYPASS;
            irs_reg <= '0;
            dr_reg <= '0;
            tdo_reg <= 1'b0;
        end else begin
            tap_reg <= tap_next;
            ir_reg <= ir_next;
            irs_reg <= irs_next;
            dr_reg <= dr_next;
            tdo_reg <= tdo_next;
        end
    end
    assign tdo_o = tdo_reg;
endmodule

// File: dir_link_if.sv
`timescale 1ns/1ps
interface dir_link_if;
    logic read_load;
    logic shift_en;
    logic serial_in;
    logic serial_out;
    modport device (input read_load, input shift_en, input serial_in, output serial_out);
    modport fabric (output read_load, output shift_en, output serial_in, input serial_out);
endinterface

// File: dir_link_props.sv
`timescale 1ns/1ps
module dir_link_props #(
    parameter logic [95:0] ID_VALUE = 96'h0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic read_load,
    input wire logic shift_en,
    input wire logic serial_in,
    input wire logic serial_out
);
    logic [95:0] ref_reg;
    logic [95:0] ref_next;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // reference copy of the identifier shift register
    always_comb begin
        ref_next = ref_reg;
        if (read_load) begin
            ref_next = ID_VALUE;
        end else if (shift_en) begin
            ref_next = {serial_in, ref_reg[95:1]};
        end
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_reg <= 96'h0;
        end else begin
            ref_reg <= ref_next;
        end
    end
    property p_follow; serial_out == ref_reg[0]; endproperty
    property p_load_one; read_load |=> serial_out; endproperty
    property p_hold; !read_load && !shift_en |=> $stable(serial_out); endproperty
    property p_low_mark; read_load ##1 (shift_en && !read_load) |=> !serial_out; endproperty
    property p_msb_mark; $past(read_load, 96) && shift_en |-> serial_out && !$past(serial_out); endproperty
    property p_load_pulse; read_load |=> !read_load; endproperty
    property p_shift_run; read_load |=> shift_en [*8]; endproperty
    property p_no_overlap; shift_en |-> !read_load; endproperty
    a_follow: assert property (p_follow) else $error("serial out off reference");
    a_load_one: assert property (p_load_one) else $error("no one after load");
    a_hold: assert property (p_hold) else $error("idle output moved");
    a_low_mark: assert property (p_low_mark) else $error("bit one not zero");
    a_msb_mark: assert property (p_msb_mark) else $error("top marks wrong");
    a_load_pulse: assert property (p_load_pulse) else $error("load held");
    a_shift_run: assert property (p_shift_run) else $error("no shift after load");
    a_no_overlap: assert property (p_no_overlap) else $error("shift with load");
    c_read: cover property (read_load ##1 shift_en);
    c_recirc: cover property (shift_en && serial_in && serial_out);
    c_end: cover property (shift_en ##1 !shift_en);
endmodule

// File: dir_pkg.sv
package dir_pkg;
    localparam int ID_WIDTH = 96;
    localparam int FUSE_WIDTH = 32;
    // fixed end markers of the identifier
    localparam logic [1:0] ID_LSB_MARK = 2'h1;
    localparam logic [1:0] ID_MSB_MARK = 2'h2;
    localparam int ID_MSB_POS = 94;
    // test port instruction width and private codes
    localparam int IR_WIDTH = 6;
    localparam logic [5:0] IR_IDENTIFIER_READ = 6'h32;
    localparam logic [5:0] IR_USER_FUSE_READ = 6'h33;
    localparam logic [5:0] IR_BYPASS = 6'h3f;
    typedef enum logic [1:0] {
        DIR_OP_HOLD,
        DIR_OP_LOAD,
        DIR_OP_SHIFT
    } dir_op_type;
endpackage

// File: dir_shift_reg.sv
`timescale 1ns/1ps
module dir_shift_reg #(
    parameter int WIDTH = 96
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic load_i,
    input wire logic shift_i,
    input wire logic serial_i,
    input wire logic [WIDTH-1:0] load_value_i,
    output logic serial_o
);
    import dir_pkg::*;
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;

    initial begin
        if (WIDTH < 2) $error("width too small");
    end

    // load wins over shift; otherwise hold
    always_comb begin
        data_next = data_reg;
        if (load_i) begin
            data_next = load_value_i;
        end else if (shift_i) begin
            data_next = {serial_i, data_reg[WIDTH-1:1]};
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_reg <= '0;
        end else begin
            data_reg <= data_next;
        end
    end

    assign serial_o = data_reg[0];
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dir_pkg::*;
    localparam logic [91:0] BODY = 92'h5a3c96e1f0d2b4870c1e2f3;
    localparam logic [31:0] FUSE = 32'h9d4c2b71;
    logic tck_i = 1'b0;
    logic tms_i = 1'b1;
    logic tdi_i = 1'b0;
    logic tdo_o;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0;
    logic [1:0] fill_mode_i = 2'h0;
    logic fill_bit_i = 1'b0;
    logic busy_o;
    logic done_o;
    logic [95:0] id_o;
    logic [31:0] seed = 32'h41e3f721;
    int fails = 0;
    int comparisons = 0;
    dir_link_if link ();
    dir_identifier_access_port #(.ID_BODY(BODY), .USER_FUSE(FUSE)) dir_identifier_access_port_i (.clk_i(clk_i),
        .reset_i(reset_i), .link(link), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o));
    dir_fabric_reader dir_fabric_reader_i (.clk_i(clk_i), .reset_i(reset_i), .link(link), .start_i(start_i),
        .fill_mode_i(fill_mode_i), .fill_bit_i(fill_bit_i), .busy_o(busy_o), .done_o(done_o), .id_o(id_o));
    dir_link_props #(.ID_VALUE({ID_MSB_MARK, BODY, ID_LSB_MARK})) dir_link_props_i (.clk_i(clk_i),
        .reset_i(reset_i), .read_load(link.read_load), .shift_en(link.shift_en), .serial_in(link.serial_in),
        .serial_out(link.serial_out));
    // clock
    initial forever #12.5 clk_i = ~clk_i;
    // expectations and helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [95:0] exp_id();
        return {ID_MSB_MARK, BODY, ID_LSB_MARK};
    endfunction
    function automatic logic exp_tail(input logic [1:0] mode, input logic fill);
        return (mode == 2'h1) ? 1'b1 : fill;
    endfunction
    task automatic cmp_bit(input string n, input logic e, input logic s);
        comparisons++;
        if (s !== e) begin fails++; $display("[ERR] %s exp %b got %b", n, e, s); end
    endtask
    task automatic cmp_id(input string n, input logic [95:0] e, input logic [95:0] s);
        comparisons++;
        if (s !== e) begin fails++; $display("[ERR] %s exp %h got %h", n, e, s); end
    endtask
    task automatic cmp_cnt(input string n, input int e, input int s);
        comparisons++;
        if (s != e) begin fails++; $display("[ERR] %s exp %0d got %0d", n, e, s); end
    endtask
    task automatic print_verdict();
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one whole read, optionally poking start while busy
    task automatic run_read(input logic [1:0] mode, input logic fill, input logic poke);
        int n;
        @(posedge clk_i); #2;
        fill_mode_i = mode;
        fill_bit_i = fill;
        start_i = 1'b1;
        @(posedge clk_i); #2;
        start_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 200) begin
            @(posedge clk_i); #2;
            n++;
            start_i = poke && n == 40;
            if (n == 40) cmp_bit("busy", 1'b1, busy_o);
        end
        if (n >= 200) begin fails++; print_verdict(); end
        cmp_cnt("latency", 97, n);
        cmp_id("id", exp_id(), id_o);
        @(posedge clk_i); #2;
        cmp_bit("done", 1'b0, done_o);
        cmp_bit("tail", exp_tail(mode, fill), link.serial_out);
    endtask
    // one test clock period, slow against clk_i so the synchroniser sees both edges
    task automatic tap_tick(input logic tms, input logic tdi);
        tms_i = tms;
        tdi_i = tdi;
        repeat (4) @(posedge clk_i);
        #2 tck_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #2 tck_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #2;
    endtask
    // load an instruction, walk to shift-dr and check every bit on tdo, then the fed-in bit
    task automatic tap_read(input logic [5:0] code, input logic [95:0] e, input logic tail);
        int k;
        tap_tick(1'b0, 1'b0);
        tap_tick(1'b1, 1'b0);
        tap_tick(1'b1, 1'b0);
        tap_tick(1'b0, 1'b0);
        tap_tick(1'b0, 1'b0);
        for (k = 0; k < 6; k++) begin
            tap_tick(k == 5, code[k]);
        end
        tap_tick(1'b1, 1'b0);
        tap_tick(1'b0, 1'b0);
        tap_tick(1'b1, 1'b0);
        tap_tick(1'b0, 1'b0);
        tap_tick(1'b0, 1'b0);
        cmp_bit("tdo_first", e[0], tdo_o);
        for (k = 1; k < 97; k++) begin
            tap_tick(1'b0, tail);
            if (k < 96) cmp_bit("tdo_bit", e[k], tdo_o);
            else cmp_bit("tdo_tail", tail, tdo_o);
        end
        tap_tick(1'b1, 1'b0);
        tap_tick(1'b1, 1'b0);
        tap_tick(1'b0, 1'b0);
    endtask
    // reset, corner cases, then random reads
    initial begin
        repeat (10) @(posedge clk_i);
        #2 reset_i = 1'b0;
        run_read(2'h1, 1'b0, 1'b1);
        run_read(2'h0, 1'b1, 1'b0);
        run_read(2'h2, 1'b0, 1'b0);
        run_read(2'h3, 1'b1, 1'b1);
        repeat (6) begin
            seed = xs(seed);
            run_read(seed[1:0], seed[2], seed[3]);
        end
        tap_read(IR_IDENTIFIER_READ, exp_id(), 1'b1);
        seed = xs(seed);
        tap_read(IR_USER_FUSE_READ, {64'h0, FUSE}, seed[4]);
        print_verdict();
    end
endmodule
